// ---- hw/gpport_pkg.sv ----
// Operation
// [RULE1] function enable 0: direction and output value drive pin, level readable
// [RULE2] function enable 1: peripheral data and enable drive the pin
// [RULE3] reset clears every function enable bit
// [RULE4] software sets function enable before enabling the peripheral function
// [RULE5] direction 0 is input, buffer off; 1 is output, buffer on
// [RULE6] reset clears every direction bit
// [RULE7] level input is read-only and shows present pin levels, outputs too
// [RULE8] output value write sets driven level; read returns last write
// [RULE9] output value keeps contents across reset
// [RULE10] pull-up only in general mode with buffer off; never in alternate mode
// [RULE11] reset clears every pull-up enable bit
// [RULE12] slew select picks slow or fast slew in both modes
// [RULE13] reset clears every slew select bit
// [RULE14] function choice picks one of two peripherals, only when enabled
// [RULE15] choice routes to fixed per-pin pair; software clears unused choices
// [RULE16] open drain: output value 0, direction toggles between zero and float
// [RULE17] registers are byte wide, bit n controls pin n, all but input writable
// [RULE18] input buffer on during level reads in general mode, always in alternate; code enables it for the access cycle, after prdata took the level
// [RULE19] each peripheral gives separate data and enable, muxed in alternate mode
package gpport_pkg;
  localparam int          GPPORT_W          = 8;
  localparam logic [11:0] GPPORT_OFF_FEN    = 12'h000;
  localparam logic [11:0] GPPORT_OFF_DIR    = 12'h004;
  localparam logic [11:0] GPPORT_OFF_LVL    = 12'h008;
  localparam logic [11:0] GPPORT_OFF_OUT    = 12'h00C;
  localparam logic [11:0] GPPORT_OFF_PU     = 12'h010;
  localparam logic [11:0] GPPORT_OFF_SLEW   = 12'h014;
  localparam logic [11:0] GPPORT_OFF_CHOICE = 12'h018;
  localparam logic [7:0]  GPPORT_RST_CLEAR  = 8'h00;
  localparam logic [7:0]  GPPORT_ALL_ONES   = 8'hFF;
  typedef enum logic [1:0] {
    GPPORT_IDLE   = 2'b00,
    GPPORT_ACCESS = 2'b01
  } gpport_state_t;
endpackage : gpport_pkg

// ---- hw/gpport_sync.sv ----
`timescale 1ns/1ps
// three-stage pin synchroniser; a change counts once stages two and three agree
module gpport_sync
  import gpport_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [GPPORT_W-1:0] pin_async,
  output logic      [GPPORT_W-1:0] pin_level
);
  logic [GPPORT_W-1:0] s1;
  logic [GPPORT_W-1:0] s2;
  logic [GPPORT_W-1:0] s3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= GPPORT_RST_CLEAR;
      s2 <= GPPORT_RST_CLEAR;
      s3 <= GPPORT_RST_CLEAR;
    end else begin
      s1 <= pin_async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // agreement filter suppresses a single-cycle metastable glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level <= GPPORT_RST_CLEAR;
    end else begin
      pin_level <= (s2 & s3) | (pin_level & (s2 | s3));
    end
  end
endmodule : gpport_sync

// ---- hw/gpport_top.sv ----
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
module gpport_top
  import gpport_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [GPPORT_W-1:0] pin_in,
  output logic      [GPPORT_W-1:0] pin_out,
  output logic      [GPPORT_W-1:0] pin_oe_n,
  output logic      [GPPORT_W-1:0] pin_pullup,
  output logic      [GPPORT_W-1:0] pin_fast_slew,
  output logic      [GPPORT_W-1:0] pin_in_buf_en,
  input  wire logic [GPPORT_W-1:0] periph0_out,
  input  wire logic [GPPORT_W-1:0] periph0_oe,
  input  wire logic [GPPORT_W-1:0] periph1_out,
  input  wire logic [GPPORT_W-1:0] periph1_oe,
  output logic      [GPPORT_W-1:0] periph0_in,
  output logic      [GPPORT_W-1:0] periph1_in
);
  logic [GPPORT_W-1:0] pin_function_enable;
  logic [GPPORT_W-1:0] pin_direction;
  logic [GPPORT_W-1:0] pin_output_value;
  logic [GPPORT_W-1:0] pin_pullup_enable;
  logic [GPPORT_W-1:0] pin_slew_select;
  logic [GPPORT_W-1:0] pin_function_choice;
  logic [GPPORT_W-1:0] pin_level_input;
  logic [GPPORT_W-1:0] next_out;
  logic [GPPORT_W-1:0] next_oe;
  logic                wr_go;
  logic                rd_go;
  logic                addr_ok;
  logic                lvl_read_setup;

  function automatic logic decode_ok(input logic [11:0] a);
    case (a)
      GPPORT_OFF_FEN, GPPORT_OFF_DIR, GPPORT_OFF_LVL, GPPORT_OFF_OUT,
      GPPORT_OFF_PU, GPPORT_OFF_SLEW, GPPORT_OFF_CHOICE: decode_ok = 1'b1;
      default: decode_ok = 1'b0;
    endcase
  endfunction : decode_ok

  // zero-wait slave: pready rises in the access cycle itself
  assign addr_ok        = decode_ok(paddr);
  assign wr_go          = psel & penable & pwrite & pready & addr_ok & pstrb[0];
  assign rd_go          = psel & penable & ~pwrite & pready;
  assign lvl_read_setup = psel & ~penable & ~pwrite & (paddr == GPPORT_OFF_LVL);

  gpport_sync u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (pin_in),
    .pin_level (pin_level_input)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (~decode_ok(paddr) | (pwrite & (paddr == GPPORT_OFF_LVL)));
    end
  end

  // control registers cleared by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_function_enable <= GPPORT_RST_CLEAR; // [RULE3]
      pin_direction       <= GPPORT_RST_CLEAR; // [RULE6]
      pin_pullup_enable   <= GPPORT_RST_CLEAR; // [RULE11]
      pin_slew_select     <= GPPORT_RST_CLEAR; // [RULE13]
      pin_function_choice <= GPPORT_RST_CLEAR;
    end else if (wr_go) begin
      case (paddr) // [RULE17]
        GPPORT_OFF_FEN:    pin_function_enable <= pwdata[GPPORT_W-1:0];
        GPPORT_OFF_DIR:    pin_direction       <= pwdata[GPPORT_W-1:0];
        GPPORT_OFF_PU:     pin_pullup_enable   <= pwdata[GPPORT_W-1:0];
        GPPORT_OFF_SLEW:   pin_slew_select     <= pwdata[GPPORT_W-1:0];
        GPPORT_OFF_CHOICE: pin_function_choice <= pwdata[GPPORT_W-1:0]; // [RULE15]
        default: ;
      endcase
    end
  end

  // no reset branch: contents survive reset, unknown at power-up
  always_ff @(posedge pclk) begin
    if (wr_go && paddr == GPPORT_OFF_OUT) begin
      pin_output_value <= pwdata[GPPORT_W-1:0]; // [RULE8] [RULE9]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      case (paddr)
        GPPORT_OFF_FEN:    prdata[GPPORT_W-1:0] <= pin_function_enable;
        GPPORT_OFF_DIR:    prdata[GPPORT_W-1:0] <= pin_direction;
        GPPORT_OFF_LVL:    prdata[GPPORT_W-1:0] <= pin_level_input; // [RULE7]
        GPPORT_OFF_OUT:    prdata[GPPORT_W-1:0] <= pin_output_value; // [RULE8]
        GPPORT_OFF_PU:     prdata[GPPORT_W-1:0] <= pin_pullup_enable;
        GPPORT_OFF_SLEW:   prdata[GPPORT_W-1:0] <= pin_slew_select;
        GPPORT_OFF_CHOICE: prdata[GPPORT_W-1:0] <= pin_function_choice;
        default:           prdata <= '0;
      endcase
    end else if (rd_go) begin
      prdata <= prdata;
    end
  end

  // per-pin output mux; open drain falls out of value 0 with direction toggling
  always_comb begin
    for (int i = 0; i < GPPORT_W; i++) begin
      if (pin_function_enable[i]) begin
        // choice ignored unless the pin is in alternate mode
        next_out[i] = pin_function_choice[i] ? periph1_out[i] : periph0_out[i]; // [RULE2] [RULE14] [RULE19]
        next_oe[i]  = pin_function_choice[i] ? periph1_oe[i]  : periph0_oe[i]; // [RULE15]
      end else begin
        next_out[i] = pin_output_value[i]; // [RULE1] [RULE16]
        next_oe[i]  = pin_direction[i]; // [RULE5]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out       <= GPPORT_RST_CLEAR;
      pin_oe_n      <= GPPORT_ALL_ONES;
      pin_pullup    <= GPPORT_RST_CLEAR;
      pin_fast_slew <= GPPORT_RST_CLEAR;
    end else begin
      pin_out       <= next_out;
      pin_oe_n      <= ~next_oe; // [RULE5]
      pin_pullup    <= pin_pullup_enable & ~pin_function_enable & ~pin_direction; // [RULE10]
      pin_fast_slew <= pin_slew_select; // [RULE12]
    end
  end

  // input buffers powered only when needed, saving static current
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_in_buf_en <= GPPORT_RST_CLEAR;
    end else begin
      pin_in_buf_en <= pin_function_enable | {GPPORT_W{lvl_read_setup}}; // [RULE18]
    end
  end

  // peripheral inputs see the level only on their selected function
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph0_in <= GPPORT_RST_CLEAR;
      periph1_in <= GPPORT_RST_CLEAR;
    end else begin
      periph0_in <= pin_level_input & pin_function_enable & ~pin_function_choice; // [RULE14]
      periph1_in <= pin_level_input & pin_function_enable & pin_function_choice;
    end
  end
endmodule : gpport_top

// ---- sim/gpport_checker.sv ----
`timescale 1ns/1ps
module gpport_checker
  import gpport_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  pin_oe_n,
  input wire logic [7:0]  pin_pullup,
  input wire logic [7:0]  pin_fast_slew
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  property p_answer; s_setup |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("setup not answered");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_upper; (s_done ##0 !pwrite) |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_lvl_ro; (s_done ##0 (pwrite && paddr == GPPORT_OFF_LVL)) |-> pslverr; endproperty
  a_lvl_ro: assert property (p_lvl_ro) else $error("level write accepted");
  property p_unmapped; (s_done ##0 (paddr > GPPORT_OFF_CHOICE)) |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
  property p_rst; $rose(presetn) |-> pin_oe_n == 8'hFF && pin_pullup == 8'h00
    && pin_fast_slew == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("pins not at reset state");
  // a pull-up fighting our own driver wastes current
  property p_pull; (pin_pullup & ~pin_oe_n) == 8'h00; endproperty
  a_pull: assert property (p_pull) else $error("pull-up while driving");
  // pins follow one edge after the write lands, so the write is two samples back
  property p_pull_src; !$stable(pin_pullup) |-> $past(pwrite && pready, 2); endproperty
  a_pull_src: assert property (p_pull_src) else $error("pull-up moved alone");
  property p_slew_src; !$stable(pin_fast_slew) |-> $past(pwrite && pready, 2); endproperty
  a_slew_src: assert property (p_slew_src) else $error("slew moved alone");
endmodule : gpport_checker
bind gpport_top gpport_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .pin_oe_n, .pin_pullup, .pin_fast_slew);

// ---- sim/gpport_board.sv ----
`timescale 1ns/1ps
module gpport_board
  import gpport_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic [GPPORT_W-1:0] pin_out,
  input  wire logic [GPPORT_W-1:0] pin_oe_n,
  input  wire logic [GPPORT_W-1:0] pin_pullup,
  output logic      [GPPORT_W-1:0] pin_in
);
  logic [GPPORT_W-1:0] last = 8'h00;
  always @(posedge pclk) last <= pin_in;
  // undriven, unpulled pins toggle so a stale level is never trusted
  always_comb begin
    for (int i = 0; i < GPPORT_W; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (pin_pullup[i]) pin_in[i] = 1'h1;
      else pin_in[i] = ~last[i];
    end
  end
endmodule : gpport_board

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import gpport_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pullup, pin_fast_slew, pin_in_buf_en;
  logic [7:0]  p0o, p0e, p1o, p1e;
  logic [3:0]  pstrb;
  int          fails, n_tests;
  logic [11:0] offs [5] = '{GPPORT_OFF_FEN, GPPORT_OFF_DIR, GPPORT_OFF_PU, GPPORT_OFF_SLEW,
                            GPPORT_OFF_CHOICE};
  gpport_top u_gpport_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n, .pin_pullup,
    .pin_fast_slew, .pin_in_buf_en, .periph0_out(p0o), .periph0_oe(p0e), .periph1_out(p1o),
    .periph1_oe(p1e), .periph0_in(), .periph1_in());
  gpport_board u_gpport_board (.pclk, .pin_out, .pin_oe_n, .pin_pullup, .pin_in);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // request held until the rising edge at which pready is seen high; answer taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n >= 16) fails++;
    if (n >= 16) report_and_stop();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask : wt
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, p0o, p0e, p1o, p1e} = '0;
    pstrb = 4'hF;
    fails = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    foreach (offs[i]) begin
      apb(1'h0, offs[i], 8'h00);
      chk(rd, 32'h0);
      apb(1'h1, offs[i], 8'hC3);
      apb(1'h0, offs[i], 8'h00);
      chk(rd, 32'hC3);
      apb(1'h1, offs[i], 8'h00);
    end
    $display("registers done");
    apb(1'h1, GPPORT_OFF_OUT, 8'h96);
    apb(1'h1, GPPORT_OFF_DIR, 8'hFF);
    wt(1);
    chk(pin_oe_n, 32'h0);
    chk(pin_out, 32'h96);
    wt(6);
    apb(1'h0, GPPORT_OFF_LVL, 8'h00);
    chk(rd, 32'h96);
    apb(1'h1, GPPORT_OFF_LVL, 8'h00);
    chk(er, 1'h1);
    apb(1'h1, 12'h01C, 8'h11);
    chk(er, 1'h1);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, GPPORT_OFF_OUT, 8'h00);
    chk(rd, 32'h96);
    pstrb <= 4'hE;
    apb(1'h1, GPPORT_OFF_OUT, 8'h5A);
    pstrb <= 4'hF;
    apb(1'h0, GPPORT_OFF_OUT, 8'h00);
    chk(rd, 32'h96);
    $display("general output done");
    apb(1'h1, GPPORT_OFF_OUT, 8'h00);
    apb(1'h1, GPPORT_OFF_PU, 8'hFF);
    apb(1'h1, GPPORT_OFF_DIR, 8'h0F);
    apb(1'h1, GPPORT_OFF_SLEW, 8'hA5);
    wt(1);
    chk(pin_pullup, 32'hF0);
    chk(pin_fast_slew, 32'hA5);
    chk(pin_oe_n, 32'hF0);
    wt(6);
    apb(1'h0, GPPORT_OFF_LVL, 8'h00);
    chk(rd, 32'hF0);
    $display("open drain done");
    apb(1'h1, GPPORT_OFF_CHOICE, 8'h0F);
    apb(1'h1, GPPORT_OFF_FEN, 8'hFF);
    {p0o, p0e, p1o, p1e} <= {8'hAA, 8'h3C, 8'h55, 8'h0F};
    wt(1);
    chk(pin_oe_n, 32'hC0);
    chk(pin_out & 8'h3F, 32'h25);
    chk(pin_pullup, 32'h0);
    chk(pin_in_buf_en, 32'hFF);
    apb(1'h1, GPPORT_OFF_FEN, 8'h0F);
    wt(1);
    chk(pin_oe_n, 32'hF0);
    $display("alternate done");
    report_and_stop();
  end
endmodule : testbench
